// *** hw/hardware_config_register.sv ***
`default_nettype none
module hardware_config_register
	import hw_config_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEFAULT
) (
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] wdata_i,
	input wire logic crossover_enable_strap_i,
	input wire logic phy_tx_clk_ok_i,
	input wire logic phy_rx_clk_ok_i,
	input wire logic transmit_error_set_i,
	input wire logic receive_error_set_i,
	output logic [31:0] rdata_o,
	output logic fifo_port_byte_order_o,
	output logic direct_fifo_byte_order_o,
	output logic set_to_one_bit_o,
	output logic [3:0] transmit_buffer_allocation_o,
	output fifo_split_t fifo_split_o,
	output logic soft_reset_pulse_o,
	output logic transmit_error_flag_o,
	output logic receive_error_flag_o
);
	logic strap_s1_reg, strap_s2_reg, strap_reg;
	logic txck_s1_reg, txck_s2_reg, rxck_s1_reg, rxck_s2_reg;
	logic read_seen_reg;
	logic fifo_port_byte_order_reg, direct_fifo_byte_order_reg;
	logic set_to_one_bit_reg;
	logic [3:0] alloc_reg;
	logic timeout_flag_reg;
	soft_reset_state_t sr_state_reg;
	logic [15:0] sr_count_reg;
	logic soft_reset_busy;
	logic write_ok;
	logic soft_reset_start;
	logic [14:0] tx_total, rx_total;

	// two-stage synchronisers for pin levels
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_s1_reg <= 1'b0;
			strap_s2_reg <= 1'b0;
			txck_s1_reg <= 1'b0;
			txck_s2_reg <= 1'b0;
			rxck_s1_reg <= 1'b0;
			rxck_s2_reg <= 1'b0;
		end else begin
			strap_s1_reg <= crossover_enable_strap_i;
			strap_s2_reg <= strap_s1_reg;
			txck_s1_reg <= phy_tx_clk_ok_i;
			txck_s2_reg <= txck_s1_reg;
			rxck_s1_reg <= phy_rx_clk_ok_i;
			rxck_s2_reg <= rxck_s1_reg;
		end
	end

	// strap caught once, after the synchroniser has filled with the pin level
	logic strap_taken_reg;
	logic [1:0] strap_wait_reg;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			strap_reg <= 1'b0;
			strap_taken_reg <= 1'b0;
			strap_wait_reg <= 2'h0;
		end else if (!strap_taken_reg) begin
			if (strap_wait_reg == 2'h2) begin
				strap_reg <= strap_s2_reg;
				strap_taken_reg <= 1'b1;
			end else begin
				strap_wait_reg <= strap_wait_reg + 2'h1; // sync latency, avoids reset zero
			end
		end
	end

	// writes locked until the first read
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			read_seen_reg <= 1'b0;
		end else if (rd_i) begin
			read_seen_reg <= 1'b1;
		end
	end

	assign soft_reset_busy = (sr_state_reg != SR_IDLE);
	assign write_ok = wr_i && read_seen_reg && (addr_i == HWCFG_OFFSET);
	assign soft_reset_start = write_ok && wdata_i[SOFT_RESET_BIT] && !soft_reset_busy;

	// byte order bits survive soft reset
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fifo_port_byte_order_reg <= 1'b0;
			direct_fifo_byte_order_reg <= 1'b0;
		end else if (write_ok && !soft_reset_busy) begin
			fifo_port_byte_order_reg <= wdata_i[FIFO_PORT_ORDER_BIT];
			direct_fifo_byte_order_reg <= wdata_i[DIRECT_ORDER_BIT];
		end
	end

	// soft-reset-affected configuration fields
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			set_to_one_bit_reg <= 1'b0;
			alloc_reg <= ALLOC_RESET;
		end else if (sr_state_reg == SR_DONE) begin
			set_to_one_bit_reg <= 1'b0;
			alloc_reg <= ALLOC_RESET;
		end else if (write_ok && !soft_reset_busy) begin
			set_to_one_bit_reg <= wdata_i[SET_TO_ONE_BIT];
			alloc_reg <= wdata_i[ALLOC_LSB +: 4];
		end
	end

	// soft reset sequencer with timeout
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sr_state_reg <= SR_IDLE;
			sr_count_reg <= 16'h0000;
			timeout_flag_reg <= 1'b0;
		end else begin
			case (sr_state_reg)
				SR_IDLE: begin
					if (soft_reset_start) begin
						sr_state_reg <= SR_RUN;
						sr_count_reg <= 16'h0000;
						timeout_flag_reg <= 1'b0;
					end
				end
				SR_RUN: begin
					sr_count_reg <= sr_count_reg + 16'h0001;
					if (txck_s2_reg && rxck_s2_reg) begin
						if (sr_count_reg >= 16'(RESET_CYCLES - 1)) begin
							sr_state_reg <= SR_DONE;
						end
					end else if (sr_count_reg >= 16'(TIMEOUT_CYCLES - 1)) begin
						sr_state_reg <= SR_IDLE;
						timeout_flag_reg <= 1'b1;
					end
				end
				SR_DONE: begin
					sr_state_reg <= SR_IDLE;
				end
				default: begin
					sr_state_reg <= SR_IDLE;
				end
			endcase
		end
	end

	// soft reset pulse to the rest of the device
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			soft_reset_pulse_o <= 1'b0;
		end else begin
			soft_reset_pulse_o <= (sr_state_reg == SR_DONE);
		end
	end

	// sticky error flags, cleared by completed soft reset; set wins
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			transmit_error_flag_o <= 1'b0;
			receive_error_flag_o <= 1'b0;
		end else begin
			if (transmit_error_set_i) begin
				transmit_error_flag_o <= 1'b1;
			end else if (sr_state_reg == SR_DONE) begin
				transmit_error_flag_o <= 1'b0;
			end
			if (receive_error_set_i) begin
				receive_error_flag_o <= 1'b1;
			end else if (sr_state_reg == SR_DONE) begin
				receive_error_flag_o <= 1'b0;
			end
		end
	end

	// buffer split from the transmit allocation
	assign tx_total = 15'(alloc_reg) * KB_BYTES;
	assign rx_total = TOTAL_BYTES - tx_total;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fifo_split_o <= '0;
		end else begin
			fifo_split_o.tx_status_bytes <= TX_STATUS_BYTES;
			fifo_split_o.tx_data_bytes <= tx_total - TX_STATUS_BYTES;
			fifo_split_o.rx_status_bytes <= {4'h0, rx_total[14:4]};
			fifo_split_o.rx_data_bytes <= rx_total - {4'h0, rx_total[14:4]};
		end
	end

	// registered config outputs and read data
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fifo_port_byte_order_o <= 1'b0;
			direct_fifo_byte_order_o <= 1'b0;
			set_to_one_bit_o <= 1'b0;
			transmit_buffer_allocation_o <= ALLOC_RESET;
			rdata_o <= 32'h0000_0000;
		end else begin
			fifo_port_byte_order_o <= fifo_port_byte_order_reg;
			direct_fifo_byte_order_o <= direct_fifo_byte_order_reg;
			set_to_one_bit_o <= set_to_one_bit_reg;
			transmit_buffer_allocation_o <= alloc_reg;
			rdata_o <= 32'h0000_0000;
			if (rd_i && addr_i == HWCFG_OFFSET) begin
				rdata_o[FIFO_PORT_ORDER_BIT] <= fifo_port_byte_order_reg;
				rdata_o[DIRECT_ORDER_BIT] <= direct_fifo_byte_order_reg;
				rdata_o[STRAP_BIT] <= strap_reg;
				rdata_o[SET_TO_ONE_BIT] <= set_to_one_bit_reg;
				rdata_o[ALLOC_LSB +: 4] <= alloc_reg;
				rdata_o[TIMEOUT_BIT] <= timeout_flag_reg;
				rdata_o[SOFT_RESET_BIT] <= soft_reset_busy;
			end
		end
	end
endmodule : hardware_config_register
`default_nettype wire

// *** hw/hw_config_pkg.sv ***
// How it works
// - bit 29 picks fifo port byte order, zero little, one big.
// - bit 28 picks direct fifo select byte order, zero little, one big.
// - bit 24 reads back the sampled crossover enable strap level.
// - bits 19..16 hold transmit allocation in 1KB steps, reset 5.
// - transmit status takes 512 bytes; data takes the remainder.
// - receive side gets 16KB minus the transmit allocation.
// - writing one to bit 0 starts soft reset; bit self-clears when done.
// - soft reset reinitialises registers except kept bits, clears error flags.
// - soft reset without phy clocks never completes, times out, sets bit 1.
// - writes are ignored until the host has read at least once.
// - receive status takes one sixteenth of receive space; rest is data.
`default_nettype none
package hw_config_pkg;
	localparam logic [7:0] HWCFG_OFFSET = 8'h74;
	localparam int FIFO_PORT_ORDER_BIT = 29;
	localparam int DIRECT_ORDER_BIT = 28;
	localparam int STRAP_BIT = 24;
	localparam int SET_TO_ONE_BIT = 20;
	localparam int ALLOC_LSB = 16;
	localparam int TIMEOUT_BIT = 1;
	localparam int SOFT_RESET_BIT = 0;
	localparam logic [3:0] ALLOC_RESET = 4'h5;
	localparam logic [14:0] KB_BYTES = 15'h0400;
	localparam logic [14:0] TX_STATUS_BYTES = 15'h0200;
	localparam logic [14:0] TOTAL_BYTES = 15'h4000;
	localparam int RESET_CYCLES = 16;
	localparam int TIMEOUT_CYCLES_DEFAULT = 1000;
	typedef enum logic [1:0] {
		SR_IDLE = 2'b00,
		SR_RUN = 2'b01,
		SR_DONE = 2'b10
	} soft_reset_state_t;
	typedef struct packed {
		logic [14:0] tx_data_bytes;
		logic [14:0] tx_status_bytes;
		logic [14:0] rx_data_bytes;
		logic [14:0] rx_status_bytes;
	} fifo_split_t;
endpackage : hw_config_pkg
`default_nettype wire

// *** tb/hardware_config_register_bench.sv ***
`default_nettype none
module hardware_config_register_bench
	import hw_config_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic crossover_enable_strap_i = 1'b1;
	logic phy_tx_clk_ok_i = 1'b1;
	logic phy_rx_clk_ok_i = 1'b1;
	logic transmit_error_set_i = 1'b0;
	logic receive_error_set_i = 1'b0;
	logic [7:0] addr_i;
	logic wr_i, rd_i;
	logic [31:0] wdata_i, rdata_o, rv;
	logic fifo_port_byte_order_o, direct_fifo_byte_order_o, set_to_one_bit_o;
	logic [3:0] transmit_buffer_allocation_o;
	fifo_split_t fifo_split_o;
	logic soft_reset_pulse_o, transmit_error_flag_o, receive_error_flag_o;
	int error_cnt = 0;
	int comparisons = 0;
	always #50 ref_clk_i = ~ref_clk_i;
	hardware_config_register #(.TIMEOUT_CYCLES(20)) uut (.*);
	host_model host (.ref_clk_i(ref_clk_i), .rdata_i(rdata_o), .addr_o(addr_i),
		.wr_o(wr_i), .rd_o(rd_i), .wdata_o(wdata_i));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report;
		$display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	// bounded wait for the completion pulse
	task automatic wait_pulse;
		int k;
		k = 0;
		while (soft_reset_pulse_o !== 1'b1 && k < 60) begin
			@(posedge ref_clk_i);
			#1;
			k++;
		end
	endtask : wait_pulse
	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		host.write(32'h3019_0000);
		host.read(8'h70, rv);
		check(rv, 32'h0);
		host.read(HWCFG_OFFSET, rv);
		check(rv, 32'h0105_0000);
		host.write(32'h3019_0000);
		host.read(HWCFG_OFFSET, rv);
		check(rv, 32'h3119_0000);
		check({29'h0, fifo_port_byte_order_o, direct_fifo_byte_order_o, set_to_one_bit_o}, 7);
		for (int k = 2; k <= 14; k += 12) begin
			host.write({12'h001, k[3:0], 16'h0000});
			repeat (3) @(posedge ref_clk_i);
			check({17'h0, fifo_split_o.tx_data_bytes}, k * 1024 - 512);
			check({17'h0, fifo_split_o.rx_data_bytes}, (16384 - k * 1024) * 15 / 16);
		end
		host.write(32'h2019_0000);
		transmit_error_set_i <= 1'b1;
		receive_error_set_i <= 1'b1;
		@(posedge ref_clk_i);
		transmit_error_set_i <= 1'b0;
		receive_error_set_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		check({31'h0, transmit_error_flag_o}, 1);
		check({31'h0, receive_error_flag_o}, 1);
		host.write(32'h2019_0001);
		host.read(HWCFG_OFFSET, rv);
		check(rv, 32'h2119_0001);
		wait_pulse();
		check({31'h0, soft_reset_pulse_o}, 1);
		host.read(HWCFG_OFFSET, rv);
		check(rv, 32'h2105_0000);
		check({31'h0, transmit_error_flag_o}, 0);
		check({31'h0, receive_error_flag_o}, 0);
		phy_tx_clk_ok_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		host.write(32'h2015_0001);
		repeat (50) @(posedge ref_clk_i);
		host.read(HWCFG_OFFSET, rv);
		check(rv, 32'h2115_0002);
		// second timeout, receive clock stopped this time
		phy_tx_clk_ok_i <= 1'b1;
		phy_rx_clk_ok_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		host.write(32'h2015_0001);
		host.read(HWCFG_OFFSET, rv);
		check(rv, 32'h2115_0001);
		repeat (30) @(posedge ref_clk_i);
		host.read(HWCFG_OFFSET, rv);
		check(rv, 32'h2115_0002);
		phy_rx_clk_ok_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		host.write(32'h2015_0001);
		wait_pulse();
		check({31'h0, soft_reset_pulse_o}, 1);
		host.read(HWCFG_OFFSET, rv);
		check(rv, 32'h2105_0000);
		// mid-run power-on reset with the strap low re-arms the read lock
		@(posedge ref_clk_i);
		crossover_enable_strap_i <= 1'b0;
		arst_n_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		host.write(32'h3019_0000);
		host.read(HWCFG_OFFSET, rv);
		check(rv, 32'h0005_0000);
		final_report();
	end
	// watchdog well past the expected run length
	initial begin
		#200000;
		error_cnt++;
		final_report();
	end
endmodule : hardware_config_register_bench
`default_nettype wire

// *** tb/hardware_configuration_props.sv ***
`default_nettype none
module hardware_configuration_props
	import hw_config_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic transmit_error_set_i,
	input wire logic [31:0] rdata_o,
	input wire logic fifo_port_byte_order_o,
	input wire logic direct_fifo_byte_order_o,
	input wire logic set_to_one_bit_o,
	input wire logic [3:0] transmit_buffer_allocation_o,
	input wire fifo_split_t fifo_split_o,
	input wire logic soft_reset_pulse_o,
	input wire logic transmit_error_flag_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i);
	// transmit and receive totals for the current allocation
	logic [14:0] tx_total;
	logic [14:0] rx_total;
	assign tx_total = {1'b0, transmit_buffer_allocation_o, 10'h000};
	assign rx_total = TOTAL_BYTES - tx_total;
	sequence s_pulse; soft_reset_pulse_o; endsequence
	sequence s_quiet; !soft_reset_pulse_o [*8]; endsequence
	a_tx_split_size: assert property ($past(arst_n_i) |->
		fifo_split_o.tx_data_bytes == tx_total - TX_STATUS_BYTES
		&& fifo_split_o.tx_status_bytes == TX_STATUS_BYTES) else $error("tx split wrong");
	a_rx_split_sum: assert property ($past(arst_n_i) |->
		fifo_split_o.rx_data_bytes + fifo_split_o.rx_status_bytes == rx_total)
		else $error("rx total wrong");
	a_rx_status_part: assert property ($past(arst_n_i) |->
		fifo_split_o.rx_status_bytes == (rx_total >> 4)) else $error("rx status wrong");
	a_read_fields: assert property (rd_i && !wr_i && addr_i == HWCFG_OFFSET |=>
		rdata_o[29:28] == {fifo_port_byte_order_o, direct_fifo_byte_order_o}
		&& rdata_o[20:16] == {set_to_one_bit_o, transmit_buffer_allocation_o})
		else $error("read fields differ from outputs");
	a_pulse_gap: assert property (s_pulse |=> s_quiet)
		else $error("soft reset pulse repeated");
	a_reset_clears: assert property (s_pulse |=> transmit_buffer_allocation_o == ALLOC_RESET
		&& !set_to_one_bit_o) else $error("soft reset left config");
	a_order_kept: assert property (s_pulse |=>
		$past(fifo_port_byte_order_o, 8) == fifo_port_byte_order_o) else $error("order lost");
	a_err_sticky: assert property (transmit_error_set_i |-> ##[1:3] transmit_error_flag_o)
		else $error("error flag not set");
endmodule : hardware_configuration_props
bind hardware_config_register hardware_configuration_props props_i (.*);
`default_nettype wire

// *** tb/host_model.sv ***
`default_nettype none
module host_model
	import hw_config_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [31:0] rdata_i,
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [31:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = 32'h0;
	end
	// paths halted, bit 20 set, allocation 2..14 kept by callers
	task automatic write(input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_o <= HWCFG_OFFSET;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge ref_clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask : write
	// read data lands the cycle after the strobe
	task automatic read(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge ref_clk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask : read
endmodule : host_model
`default_nettype wire
